// File: core/gdf_pkg.sv
/*
 gdf_pkg: constants, register map and enumerations of the gate driver fault manager.
 Assumes a 10 MHz mclk and a 32-bit classic Wishbone register bus.
*/
package gdf_pkg;
	localparam int CLK_MHZ = 10;
	localparam int RETRY_LONG_US = 4000;
	localparam int RETRY_SHORT_US = 70;
	localparam int RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
	localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
	localparam int RETRY_W = 16;
	localparam logic [RETRY_W-1:0] RETRY_LAST = 16'h0001;
	localparam logic [RETRY_W-1:0] RETRY_IDLE = 16'h0000;

	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] REG_PINS = 8'h08;
	localparam logic [ADR_W-1:0] REG_OUTPUTS = 8'h0C;

	// synchronised input vector
	localparam int IN_RAIL_LOW = 0;
	localparam int IN_MOTOR_LOW = 1;
	localparam int IN_MOTOR_HIGH = 2;
	localparam int IN_PUMP_LOW = 3;
	localparam int IN_DRAIN_OC = 4;
	localparam int IN_SHUNT_OC = 5;
	localparam int IN_GATE_SRC = 6;
	localparam int IN_THERM_WARN = 7;
	localparam int IN_THERM_SHUT = 8;
	localparam int IN_BUCK_LIMIT = 9;
	localparam int IN_BUCK_TRIP = 10;
	localparam int IN_DRIVE_LOW = 11;
	localparam int IN_DRIVE_HIGH = 12;
	localparam int IN_SOFT_DONE = 13;
	localparam int IN_RAILS_UP = 14;
	localparam int IN_ENABLE = 15;
	localparam int IN_LINE = 16;
	localparam int IN_W = 17;

	// status register bits
	localparam int ST_GLOBAL = 0;
	localparam int ST_MOTOR_LOW = 1;
	localparam int ST_MOTOR_HIGH = 2;
	localparam int ST_PUMP_LOW = 3;
	localparam int ST_DRAIN_OC = 4;
	localparam int ST_SHUNT_OC = 5;
	localparam int ST_GATE_SRC = 6;
	localparam int ST_THERM_WARN = 7;
	localparam int ST_THERM_SHUT = 8;
	localparam int ST_BUCK_TRIP = 9;
	localparam int ST_DRIVE_LOW = 10;
	localparam int ST_DRIVE_HIGH = 11;
	localparam int ST_W = 12;

	// control register bits
	localparam int CT_CLEAR = 0;
	localparam int CT_MOTOR_LOW_OFF = 1;
	localparam int CT_MOTOR_HIGH_OFF = 2;
	localparam int CT_PUMP_LOW_OFF = 3;
	localparam int CT_GATE_SRC_OFF = 4;
	localparam int CT_WARN_TO_LINE = 5;
	localparam int CT_THERM_SHUT_OFF = 6;
	localparam int CT_BUCK_CHECK_OFF = 7;
	localparam int CT_DRIVE_LOW_OFF = 8;
	localparam int CT_DRIVE_HIGH_OFF = 9;
	localparam int CT_PULLDOWN_SEL = 10;
	localparam int CT_SHUNT_MODE = 11;
	localparam int CT_DRAIN_MODE = 13;
	localparam int CT_RETRY_SHORT = 15;
	localparam int CT_W = 16;
	localparam logic [CT_W-1:0] CTRL_RESET = 16'h0000;

	localparam int OUT_W = 14;

	typedef enum logic [1:0] {
		GDF_OC_LATCH = 2'h0,
		GDF_OC_RETRY = 2'h1,
		GDF_OC_REPORT = 2'h2,
		GDF_OC_OFF = 2'h3
	} gdf_oc_mode_t;

	typedef enum logic [1:0] {
		GDF_SHUTDOWN = 2'h0,
		GDF_SLEEP = 2'h1,
		GDF_OPERATING = 2'h3,
		GDF_FAULT = 2'h2
	} gdf_mode_t;
endpackage

// File: core/gdf_fault_manager.sv
/*
 gdf_fault_manager: fault path of a three-phase gate driver with a Wishbone slave.
 Assumes comparator levels arrive asynchronous to mclk; regulators and gate
 stages outside obey the enables and blocks driven here.
*/
`timescale 1ns/1ns
module gdf_fault_manager
	import gdf_pkg::*;
#(
	parameter int RetryLongCycles = gdf_pkg::RETRY_LONG_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gdf_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [gdf_pkg::DAT_W-1:0] wb_dat_i,
	output logic [gdf_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic logicRailLow,
	input wire logic motorSupplyLow,
	input wire logic motorSupplyHigh,
	input wire logic pumpVoltageLow,
	input wire logic drainSourceOvercurrent,
	input wire logic shuntOvercurrent,
	input wire logic gateSourceFault,
	input wire logic thermalWarning,
	input wire logic thermalShutdown,
	input wire logic buckCurrentLimit,
	input wire logic buckOvercurrentTrip,
	input wire logic driveSupplyLow,
	input wire logic driveSupplyHigh,
	input wire logic buckSoftStartDone,
	input wire logic railsStartupDone,
	input wire logic enablePin,
	input wire logic faultLineNIn,
	output logic faultLineNOut,
	output logic faultLineNOe,
	output logic gateInputsBlocked,
	output logic gateOutputsPulledLow,
	output logic primaryKeepaliveRegEn,
	output logic logicSupplyRegEn,
	output logic logicSupplyLowPower,
	output logic gateDriveRegEn,
	output logic buckEn,
	output logic chargePumpEn,
	output logic buckHiZ,
	output logic chargePumpHiZ,
	output logic buckHiccup,
	output logic [1:0] deviceMode
);
	import gdf_pkg::*;

	typedef struct packed {
		logic [IN_W-1:0] s1;
		logic [IN_W-1:0] s2;
		logic [IN_W-1:0] s3;
		logic [IN_W-1:0] live;
		logic [CT_W-1:0] ctrl;
		logic clrPulse;
		logic enPrev;
		logic [ST_W-1:0] status;
		logic lockShut;
		logic lockPump;
		logic lockOc;
		logic lineLatch;
		logic hiccup;
		logic retryPrev;
		logic [RETRY_W-1:0] retryCnt;
		gdf_mode_t mode;
		logic [OUT_W-1:0] outs;
		logic ack;
		logic [DAT_W-1:0] dat;
	} gdf_state_t;

	localparam logic [RETRY_W-1:0] RetryLong = RETRY_W'(RetryLongCycles);
	localparam logic [RETRY_W-1:0] RetryShort = RETRY_W'(RETRY_SHORT_CYC);

	gdf_state_t r_r;
	gdf_state_t r_nxt;

	logic [IN_W-1:0] pins;
	logic [IN_W-1:0] lv;
	gdf_oc_mode_t drainMode;
	gdf_oc_mode_t shuntMode;
	logic drainAct, shuntAct, gsAct, ocStop, retryEvt, retryExpire, clearEvt;
	logic mlStop, mhStop, pumpStop, tsStop, buckStop, dlStop, dhStop;
	logic ra2Cond, ra3Cond, asleep, railLow, heavyBlock, gateBlock, lineLow;
	logic [4:0] chainKeepN;
	logic [OUT_W-1:0] outsNxt;
	logic [ST_W-1:0] stSet;
	logic [ST_W-1:0] stClr;
	logic busReq;

	assign pins = {faultLineNIn, enablePin, railsStartupDone, buckSoftStartDone,
		driveSupplyHigh, driveSupplyLow, buckOvercurrentTrip, buckCurrentLimit,
		thermalShutdown, thermalWarning, gateSourceFault, shuntOvercurrent,
		drainSourceOvercurrent, pumpVoltageLow, motorSupplyHigh, motorSupplyLow,
		logicRailLow};
	assign lv = r_r.live;
	assign railLow = lv[IN_RAIL_LOW];
	assign asleep = (r_r.mode == GDF_SHUTDOWN) || (r_r.mode == GDF_SLEEP);

	// overcurrent response per source; off mode is ignored entirely
	assign drainMode = gdf_oc_mode_t'(r_r.ctrl[CT_DRAIN_MODE +: 2]);
	assign shuntMode = gdf_oc_mode_t'(r_r.ctrl[CT_SHUNT_MODE +: 2]);
	assign drainAct = lv[IN_DRAIN_OC] && drainMode != GDF_OC_OFF;
	assign shuntAct = lv[IN_SHUNT_OC] && shuntMode != GDF_OC_OFF;
	assign gsAct = lv[IN_GATE_SRC] && !r_r.ctrl[CT_GATE_SRC_OFF];
	assign ocStop = (drainAct && drainMode != GDF_OC_REPORT)
		|| (shuntAct && shuntMode != GDF_OC_REPORT) || gsAct;
	assign retryEvt = (drainAct && drainMode == GDF_OC_RETRY)
		|| (shuntAct && shuntMode == GDF_OC_RETRY);
	assign retryExpire = r_r.retryCnt == RETRY_LAST;
	assign clearEvt = r_r.clrPulse || (lv[IN_ENABLE] && !r_r.enPrev);

	// live blocking terms of each enabled supply or thermal check
	assign mlStop = lv[IN_MOTOR_LOW] && !r_r.ctrl[CT_MOTOR_LOW_OFF];
	assign mhStop = lv[IN_MOTOR_HIGH] && !r_r.ctrl[CT_MOTOR_HIGH_OFF];
	assign pumpStop = lv[IN_PUMP_LOW] && !r_r.ctrl[CT_PUMP_LOW_OFF];
	assign tsStop = lv[IN_THERM_SHUT] && !r_r.ctrl[CT_THERM_SHUT_OFF];
	assign buckStop = lv[IN_BUCK_TRIP] && !r_r.ctrl[CT_BUCK_CHECK_OFF];
	assign dlStop = lv[IN_DRIVE_LOW] && !r_r.ctrl[CT_DRIVE_LOW_OFF];
	assign dhStop = lv[IN_DRIVE_HIGH] && !r_r.ctrl[CT_DRIVE_HIGH_OFF];
	assign ra2Cond = mhStop || tsStop || buckStop || dlStop;
	assign ra3Cond = pumpStop || dhStop;

	assign heavyBlock = railLow || mlStop || ra2Cond || ra3Cond || r_r.lockShut
		|| r_r.lockPump || r_r.hiccup || gsAct;
	assign gateBlock = asleep || heavyBlock || ocStop || r_r.lockOc;

	// each term is an active-low stop; the chain runs only if all are high
	assign chainKeepN = ~{asleep, railLow, mlStop, mhStop, tsStop};

	// buck current limit never reaches this
	assign lineLow = !railLow && (lv[IN_MOTOR_LOW] || lv[IN_MOTOR_HIGH]
		|| lv[IN_PUMP_LOW] || lv[IN_THERM_SHUT] || lv[IN_DRIVE_LOW]
		|| lv[IN_DRIVE_HIGH] || lv[IN_BUCK_TRIP] || r_r.hiccup
		|| drainAct || shuntAct || gsAct || r_r.lineLatch
		|| (lv[IN_THERM_WARN] && r_r.ctrl[CT_WARN_TO_LINE])
		|| !lv[IN_RAILS_UP]);

	assign outsNxt = {
		lineLow,
		gateBlock,
		gateBlock && !heavyBlock && r_r.ctrl[CT_PULLDOWN_SEL],
		asleep || railLow || mlStop || mhStop || tsStop
			|| buckStop || dlStop || r_r.hiccup,
		1'b1,
		asleep || railLow,
		&chainKeepN,
		&chainKeepN,
		&chainKeepN,
		dhStop,
		dhStop,
		r_r.hiccup || buckStop || dlStop,
		r_r.mode
	};

	// sticky status sets; thermal warning only mirrors its level
	always_comb begin
		stSet = '0;
		stClr = '0;
		stSet[ST_MOTOR_LOW] = lv[IN_MOTOR_LOW];
		stSet[ST_MOTOR_HIGH] = lv[IN_MOTOR_HIGH];
		stSet[ST_PUMP_LOW] = lv[IN_PUMP_LOW];
		stSet[ST_DRAIN_OC] = drainAct;
		stSet[ST_SHUNT_OC] = shuntAct;
		stSet[ST_GATE_SRC] = gsAct;
		stSet[ST_THERM_WARN] = lv[IN_THERM_WARN];
		stSet[ST_THERM_SHUT] = lv[IN_THERM_SHUT];
		stSet[ST_BUCK_TRIP] = lv[IN_BUCK_TRIP];
		stSet[ST_DRIVE_LOW] = lv[IN_DRIVE_LOW];
		stSet[ST_DRIVE_HIGH] = lv[IN_DRIVE_HIGH];
		if (railLow) begin
			stSet = '0;
		end
		stClr = {ST_W{clearEvt}};
		stClr[ST_THERM_WARN] = 1'b1;
		stClr[ST_DRAIN_OC] = clearEvt || retryExpire;
		stClr[ST_SHUNT_OC] = clearEvt || retryExpire;
	end

	assign busReq = wb_cyc_i && wb_stb_i;

	always_comb begin
		r_nxt = r_r;
		r_nxt.s1 = pins;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		r_nxt.live = (r_r.s3 & ~(r_r.s2 ^ r_r.s3)) | (r_r.live & (r_r.s2 ^ r_r.s3));
		r_nxt.enPrev = lv[IN_ENABLE];
		r_nxt.clrPulse = 1'b0;

		// set wins over clear in every sticky bit
		r_nxt.status = stSet | (r_r.status & ~stClr);
		r_nxt.status[ST_GLOBAL] = |r_nxt.status[ST_W-1:ST_GLOBAL+1];
		r_nxt.lockShut = ra2Cond || (r_r.lockShut && !clearEvt);
		r_nxt.lockPump = ra3Cond || (r_r.lockPump && !clearEvt);
		r_nxt.lockOc = ocStop || (r_r.lockOc && !clearEvt && !retryExpire);
		r_nxt.lineLatch = drainAct || shuntAct || gsAct
			|| (r_r.lineLatch && !clearEvt && !retryExpire);
		r_nxt.hiccup = buckStop || dlStop
			|| (r_r.hiccup && !lv[IN_SOFT_DONE]);

		// retry delay reloads on each rising edge of the combined drain/shunt retry-mode overcurrent event
		r_nxt.retryPrev = retryEvt;
		if (retryEvt && !r_r.retryPrev) begin
			r_nxt.retryCnt = r_r.ctrl[CT_RETRY_SHORT] ? RetryShort : RetryLong;
		end else if (r_r.retryCnt != RETRY_IDLE) begin
			r_nxt.retryCnt = r_r.retryCnt - RETRY_LAST;
		end

		if (railLow) begin
			r_nxt.mode = GDF_SHUTDOWN;
		end else begin
			case (r_r.mode)
				GDF_SHUTDOWN: r_nxt.mode = GDF_SLEEP;
				GDF_SLEEP: begin
					if (lv[IN_ENABLE]) begin
						r_nxt.mode = GDF_OPERATING;
					end
				end
				GDF_OPERATING: begin
					if (!lv[IN_ENABLE]) begin
						r_nxt.mode = GDF_SLEEP;
					end else if (gateBlock || lineLow) begin
						r_nxt.mode = GDF_FAULT;
					end
				end
				default: begin
					if (!lv[IN_ENABLE]) begin
						r_nxt.mode = GDF_SLEEP;
					end else if (!(gateBlock || lineLow)) begin
						r_nxt.mode = GDF_OPERATING;
					end
				end
			endcase
		end
		r_nxt.outs = outsNxt;

		// classic Wishbone: ack one cycle after request, write at the ack edge
		r_nxt.ack = busReq && !r_r.ack;
		if (busReq && !r_r.ack) begin
			if (wb_adr_i == REG_CTRL) begin
				r_nxt.dat = DAT_W'(r_r.ctrl);
			end else if (wb_adr_i == REG_STATUS) begin
				r_nxt.dat = DAT_W'(r_r.status);
			end else if (wb_adr_i == REG_PINS) begin
				r_nxt.dat = DAT_W'(r_r.live);
			end else if (wb_adr_i == REG_OUTPUTS) begin
				r_nxt.dat = DAT_W'(r_r.outs);
			end else begin
				r_nxt.dat = '0;
			end
		end
		if (busReq && r_r.ack && wb_we_i && wb_adr_i == REG_CTRL) begin
			if (wb_sel_i[0]) begin
				r_nxt.ctrl[7:0] = wb_dat_i[7:0];
				r_nxt.ctrl[CT_CLEAR] = 1'b0;
				r_nxt.clrPulse = wb_dat_i[CT_CLEAR];
			end
			if (wb_sel_i[1]) begin
				r_nxt.ctrl[15:8] = wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_r <= '{
				s1: '0, s2: '0, s3: '0, live: '0,
				ctrl: CTRL_RESET, clrPulse: 1'b0, enPrev: 1'b0,
				status: '0, lockShut: 1'b0, lockPump: 1'b0, lockOc: 1'b0,
				lineLatch: 1'b0, hiccup: 1'b0, retryPrev: 1'b0,
				retryCnt: RETRY_IDLE, mode: GDF_SHUTDOWN, outs: '0,
				ack: 1'b0, dat: '0
			};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign wb_ack_o = r_r.ack;
	assign wb_dat_o = r_r.dat;
	assign faultLineNOut = 1'b0;
	assign {faultLineNOe, gateInputsBlocked, gateOutputsPulledLow, primaryKeepaliveRegEn,
		logicSupplyRegEn, logicSupplyLowPower, gateDriveRegEn, buckEn, chargePumpEn,
		buckHiZ, chargePumpHiZ, buckHiccup, deviceMode} = r_r.outs;
endmodule

// File: testbench/gdf_fm_sva.sv
/*
 gdf_fm_sva: port-level assertions for the fault manager.
 Assumes pins are held steady for several cycles between changes.
*/
`timescale 1ns/1ns
module gdf_fm_sva
	import gdf_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic logicRailLow,
	input wire logic motorSupplyLow,
	input wire logic railsStartupDone,
	input wire logic faultLineNOut,
	input wire logic faultLineNOe,
	input wire logic gateInputsBlocked,
	input wire logic primaryKeepaliveRegEn,
	input wire logic logicSupplyRegEn,
	input wire logic gateDriveRegEn,
	input wire logic buckEn,
	input wire logic chargePumpEn,
	input wire logic [1:0] deviceMode
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// six samples cover the input synchroniser and the output register
	sequence railDown;
		// one more for the registered mode copy in the outputs
		(logicRailLow && railsStartupDone)[*7];
	endsequence
	sequence motorDown;
		(motorSupplyLow && !logicRailLow)[*6];
	endsequence
	chk_open_drain: assert property (!faultLineNOut)
		else $error("fault line driven high");
	chk_startup_low: assert property ((!railsStartupDone && !logicRailLow)[*6] |-> faultLineNOe)
		else $error("line released before rails up");
	chk_motor_line: assert property (motorDown |-> faultLineNOe)
		else $error("line not low on motor undervoltage");
	chk_rail_shut: assert property (railDown |-> gateInputsBlocked && deviceMode == 2'h0)
		else $error("no shutdown on rail low");
	chk_rail_quiet: assert property (railDown |-> !faultLineNOe)
		else $error("rail low reported on line");
	chk_rail_regs: assert property (railDown |-> primaryKeepaliveRegEn && logicSupplyRegEn
		&& !buckEn && !chargePumpEn && !gateDriveRegEn)
		else $error("regulators wrong on rail low");
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
endmodule
bind gdf_fault_manager gdf_fm_sva chk_i (.*);

// File: testbench/gdf_host_line.sv
/*
 gdf_host_line: host side of the open-drain fault line.
 Assumes a pull-up on the line; the design only pulls low.
*/
`timescale 1ns/1ns
module gdf_host_line (
	input wire logic faultLineNOut,
	input wire logic faultLineNOe,
	output logic lineLevel
);
	// pull-up wins when nobody pulls low
	assign lineLevel = faultLineNOe ? faultLineNOut : 1'b1;
endmodule

// File: testbench/testbench.sv
/*
 testbench: directed fault scenarios on the fault manager.
 Assumes the host line model and the bound checker.
*/
`timescale 1ns/1ns
module testbench;
	import gdf_pkg::*;
	localparam int RETRY = 50;
	logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic logicRailLow, motorSupplyLow, motorSupplyHigh, pumpVoltageLow;
	logic drainSourceOvercurrent, shuntOvercurrent, gateSourceFault, thermalWarning;
	logic thermalShutdown, buckCurrentLimit, buckOvercurrentTrip, driveSupplyLow;
	logic driveSupplyHigh, buckSoftStartDone, railsStartupDone, enablePin, faultLineNIn;
	logic faultLineNOut, faultLineNOe, gateInputsBlocked, gateOutputsPulledLow;
	logic primaryKeepaliveRegEn, logicSupplyRegEn, logicSupplyLowPower, gateDriveRegEn;
	logic buckEn, chargePumpEn, buckHiZ, chargePumpHiZ, buckHiccup;
	logic [1:0] deviceMode;
	int n_mismatch = 0;
	int checks_done = 0;
	gdf_fault_manager #(.RetryLongCycles(RETRY)) DUT (.*);
	gdf_host_line host (.faultLineNOut, .faultLineNOe, .lineLevel(faultLineNIn));
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic step(int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_mismatch++;
			close_out();
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		step(6);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e, m);
	endtask
	task automatic s_latch();
		@(posedge mclk) drainSourceOvercurrent <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 3, "oc trip");
		rd(REG_STATUS, 32'h0000_0011, "oc status");
		@(posedge mclk) drainSourceOvercurrent <= 0;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 3, "oc held");
		wr(REG_CTRL, 32'h0000_0001);
		chk({faultLineNOe, gateInputsBlocked}, 0, "oc cleared");
		rd(REG_STATUS, 32'h0000_0000, "oc status cleared");
		rd(REG_CTRL, 32'h0000_0000, "clear self-clears");
	endtask
	task automatic s_motor();
		@(posedge mclk) motorSupplyLow <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, buckEn, chargePumpEn, gateDriveRegEn,
			primaryKeepaliveRegEn}, 6'b110001, "motor low");
		@(posedge mclk) motorSupplyLow <= 0;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 0, "motor low gone");
		rd(REG_STATUS, 32'h0000_0003, "motor status kept");
		@(posedge mclk) enablePin <= 0;
		step(8);
		@(posedge mclk) enablePin <= 1;
		step(8);
		rd(REG_STATUS, 32'h0000_0000, "enable pulse clears");
	endtask
	task automatic s_over();
		@(posedge mclk) motorSupplyHigh <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, buckEn}, 3'b110, "motor high");
		@(posedge mclk) motorSupplyHigh <= 0;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 1, "line back, gates held");
		wr(REG_CTRL, 32'h0000_0001);
		chk(gateInputsBlocked, 0, "gates back");
	endtask
	task automatic s_ocmodes();
		wr(REG_CTRL, 32'h0000_0C00);
		@(posedge mclk) shuntOvercurrent <= 1;
		step(8);
		@(posedge mclk) shuntOvercurrent <= 0;
		chk({faultLineNOe, gateOutputsPulledLow}, 3, "retry trip");
		step(RETRY + 10);
		chk({faultLineNOe, gateInputsBlocked}, 0, "retry expired");
		rd(REG_STATUS, 32'h0000_0000, "retry status");
		wr(REG_CTRL, 32'h0000_4000);
		@(posedge mclk) drainSourceOvercurrent <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 2, "report only");
		@(posedge mclk) drainSourceOvercurrent <= 0;
		step(8);
		wr(REG_CTRL, 32'h0000_4001);
		chk(faultLineNOe, 0, "report cleared");
		wr(REG_CTRL, 32'h0000_6000);
		@(posedge mclk) drainSourceOvercurrent <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 0, "oc off");
		rd(REG_STATUS, 32'h0000_0000, "oc off status");
		@(posedge mclk) drainSourceOvercurrent <= 0;
		step(8);
	endtask
	task automatic s_gate();
		wr(REG_CTRL, 32'h0000_0400);
		@(posedge mclk) gateSourceFault <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, gateOutputsPulledLow}, 3'b110, "gate-source");
		rd(REG_STATUS, 32'h0000_0041, "gate-source status");
		@(posedge mclk) gateSourceFault <= 0;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 3, "gate-source held");
		wr(REG_CTRL, 32'h0000_0001);
		chk({faultLineNOe, gateInputsBlocked}, 0, "gate-source cleared");
		@(posedge mclk) pumpVoltageLow <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, primaryKeepaliveRegEn, buckEn}, 4'hD, "pump low");
		@(posedge mclk) {pumpVoltageLow, railsStartupDone} <= 2'b00;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 3, "rails not up");
		@(posedge mclk) railsStartupDone <= 1;
		wr(REG_CTRL, 32'h0000_0001);
		chk({faultLineNOe, gateInputsBlocked}, 0, "pump cleared");
	endtask
	task automatic s_buck();
		@(posedge mclk) {buckSoftStartDone, buckOvercurrentTrip} <= 2'b01;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, buckHiccup, primaryKeepaliveRegEn}, 4'hF, "buck trip");
		@(posedge mclk) buckOvercurrentTrip <= 0;
		step(8);
		chk({buckHiccup, faultLineNOe}, 3, "hiccup until soft-start");
		@(posedge mclk) buckSoftStartDone <= 1;
		step(8);
		chk({buckHiccup, faultLineNOe, gateInputsBlocked}, 1, "gates wait for clear");
		wr(REG_CTRL, 32'h0000_0001);
		chk(gateInputsBlocked, 0, "buck cleared");
	endtask
	task automatic s_motor_off();
		wr(REG_CTRL, 32'h0000_0002);
		@(posedge mclk) motorSupplyLow <= 1;
		step(8);
		chk({faultLineNOe, gateInputsBlocked, buckEn}, 3'b101, "motor low, check off");
		@(posedge mclk) motorSupplyLow <= 0;
		step(8);
		chk(faultLineNOe, 0, "line follows condition");
		rd(REG_STATUS, 32'h0000_0003, "status kept");
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_STATUS, 32'h0000_0000, "status cleared");
	endtask
	task automatic s_misc();
		wr(REG_CTRL, 32'h0000_0000);
		@(posedge mclk) {thermalWarning, buckCurrentLimit} <= 2'b11;
		step(8);
		chk({faultLineNOe, gateInputsBlocked}, 0, "warn silent");
		rd(REG_STATUS, 32'h0000_0081, "warn status, no buck");
		wr(REG_CTRL, 32'h0000_0020);
		chk(faultLineNOe, 1, "warn on line");
		@(posedge mclk) {thermalWarning, buckCurrentLimit} <= 2'b00;
		step(8);
		chk(faultLineNOe, 0, "warn gone");
		@(posedge mclk) driveSupplyHigh <= 1;
		step(8);
		chk({gateInputsBlocked, buckHiZ, chargePumpHiZ, gateDriveRegEn}, 4'hF, "drive high");
		@(posedge mclk) driveSupplyHigh <= 0;
		step(8);
		chk({buckHiZ, chargePumpHiZ}, 0, "hi-z released");
		@(posedge mclk) logicRailLow <= 1;
		step(8);
		chk({deviceMode, faultLineNOe}, 0, "rail low");
		chk(logicSupplyLowPower, 1, "rail low, logic supply low power");
		@(posedge mclk) logicRailLow <= 0;
		rd(8'h10, 32'h0000_0000, "unmapped");
	endtask
	initial begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'hF;
		{logicRailLow, motorSupplyLow, motorSupplyHigh, pumpVoltageLow} = 4'h0;
		{drainSourceOvercurrent, shuntOvercurrent, gateSourceFault, thermalWarning} = 4'h0;
		{thermalShutdown, buckCurrentLimit, buckOvercurrentTrip, driveSupplyLow} = 4'h0;
		{driveSupplyHigh, buckSoftStartDone, railsStartupDone, enablePin} = 4'h7;
		step(3);
		reset <= 0;
		rd(REG_CTRL, 32'h0000_0000, "ctrl reset");
		step(8);
		s_latch();
		s_motor();
		s_over();
		s_ocmodes();
		s_gate();
		s_buck();
		s_motor_off();
		s_misc();
		close_out();
	end
	initial begin
		#2000000;
		n_mismatch++;
		close_out();
	end
endmodule
